// ===== verilog/rtc_counter_core.sv
// Real-time counter core with prescaler, wrap and match flags, AXI4-Lite.
//
// Summary of operation
// R1: Standby stops counter unless keep_in_standby set.
// R2: tick_divider divides timekeeping clock by 2^code.
// R3: Control writes act after two timekeeping cycles.
// R4: Software waits control busy clear before writing.
// R5: counter_on bit enables or disables counting.
// R6: Busy bits show pending compare/limit/count/control sync.
// R7: Enable bit 1 gates the match interrupt.
// R8: Enable bit 0 gates the wrap interrupt.
// R9: match_flag sets when count equals compare.
// R10: Count to wrap_limit, wrap to zero, set wrap_flag.
// R11: Writing one clears a flag; zero keeps.
// R12: One shared byte latch serves all 16-bit registers.
// R13: Debug halt stops counter unless run_on_halt set.
// R14: source_choice picks fast, slow or external source.
// R15: count_value is 16 bits, resets to zero.
// R16: Count and limit writes act after two cycles.
// R17: Software waits count busy clear before writing.
// R18: wrap_limit is 16 bits, resets to all ones.
// R19: Software waits limit busy clear before writing.
// R20: Interrupt stays asserted while flag and enable set.
// R21: Counting runs on timekeeping ticks, not bus clock.
// R22: Low read latches high; low write commits both.
// R23: Count increments per divided tick while enabled.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps

module rtc_counter_core
  import rtc_counter_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_power_osc_i,
  input wire logic ext_clk_i,
  input wire logic standby_i,
  input wire logic debug_halt_i,
  output logic irq_o
);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Source pipelines: bit 0 and 1 synchronise, bit 2 holds the last level.
  logic [2:0] osc_pipe_q, osc_pipe_d;
  logic [2:0] ext_pipe_q, ext_pipe_d;
  logic [4:0] slow_div_q, slow_div_d;
  logic [14:0] presc_q, presc_d;
  logic fast_edge, slow_tick, ext_edge, rtc_tick, run, cnt_tick;
  logic [14:0] div_mask;

  // Register state; the _act copies are what the timekeeping logic uses.
  logic [7:0] ctrl_q, ctrl_d, ctrl_act_q, ctrl_act_d;
  logic [15:0] cnt_q, cnt_d, cnt_new_q, cnt_new_d;
  logic [15:0] lim_q, lim_d, lim_act_q, lim_act_d;
  logic [15:0] cmp_q, cmp_d, cmp_act_q, cmp_act_d;
  logic [1:0] en_q, en_d, flags_q, flags_d, src_q, src_d;
  logic [7:0] latch_q, latch_d;
  logic halt_run_q, halt_run_d;
  logic [3:0] busy_q, busy_d, apply_w;
  logic [1:0] stage_q [4];
  logic [1:0] stage_d [4];

  // Bus state.
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr, rd, wr_b0;
  logic [3:0] widx, ridx;
  logic [7:0] wbyte, rbyte;
  logic rmapped, wmapped;
  logic [1:0] flag_set;

  function automatic logic is_mapped(input logic [3:0] idx);
    is_mapped = (idx <= IDX_HALT) || (idx >= IDX_SRC && idx <= IDX_CMP_HI);
  endfunction

  // Both write channels are taken together, one response outstanding.
  assign wr = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign rd = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = wr;
  assign s_axi_wready = wr;
  assign s_axi_arready = rd;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign widx = s_axi_awaddr[5:2];
  assign ridx = s_axi_araddr[5:2];
  assign wbyte = s_axi_wdata[7:0];
  assign wmapped = is_mapped(widx);
  assign rmapped = is_mapped(ridx);
  assign wr_b0 = wr && wmapped && s_axi_wstrb[0];

  // Timekeeping tick selection; only one clock, so ticks are enables.
  always_comb begin
    osc_pipe_d = {osc_pipe_q[1:0], low_power_osc_i};
    ext_pipe_d = {ext_pipe_q[1:0], ext_clk_i};
    fast_edge = osc_pipe_q[1] && !osc_pipe_q[2];
    ext_edge = ext_pipe_q[1] && !ext_pipe_q[2];
    slow_tick = fast_edge && (slow_div_q == SLOW_LAST);
    slow_div_d = slow_div_q;
    if (fast_edge) slow_div_d = slow_tick ? 5'h00 : slow_div_q + 5'h01;
    unique case (src_q) // [R14]
      SRC_FAST: rtc_tick = fast_edge;
      SRC_SLOW: rtc_tick = slow_tick;
      SRC_EXT: rtc_tick = ext_edge;
      default: rtc_tick = 1'b0;
    endcase
  end

  // Prescaler: a divided tick when the low code bits of the count are ones.
  always_comb begin
    run = ctrl_act_q[CTRL_ON_BIT] // [R5]
      && !(standby_i && !ctrl_act_q[CTRL_STANDBY_BIT]) // [R1]
      && !(debug_halt_i && !halt_run_q); // [R13]
    div_mask = 15'((32'h1 << ctrl_act_q[CTRL_DIV_MSB:CTRL_DIV_LSB]) - 1);
    cnt_tick = rtc_tick && run && ((presc_q & div_mask) == div_mask); // [R2]
    presc_d = presc_q;
    if (!ctrl_act_q[CTRL_ON_BIT]) begin
      presc_d = 15'h0000;
    end else if (rtc_tick && run) begin // [R21]
      presc_d = presc_q + 15'h0001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_pipe_q <= 3'h0;
      ext_pipe_q <= 3'h0;
      slow_div_q <= 5'h00;
      presc_q <= 15'h0000;
    end else begin
      osc_pipe_q <= osc_pipe_d;
      ext_pipe_q <= ext_pipe_d;
      slow_div_q <= slow_div_d;
      presc_q <= presc_d;
    end
  end

  // Sync stages: a written value reaches the counter on the second tick.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      apply_w[i] = busy_q[i] && rtc_tick && (stage_q[i] == SYNC_TICKS - 2'h1);
    end
  end

  // Register file, counter and flags, computed together.
  always_comb begin
    ctrl_d = ctrl_q;
    ctrl_act_d = ctrl_act_q;
    cnt_d = cnt_q;
    cnt_new_d = cnt_new_q;
    lim_d = lim_q;
    lim_act_d = lim_act_q;
    cmp_d = cmp_q;
    cmp_act_d = cmp_act_q;
    en_d = en_q;
    src_d = src_q;
    latch_d = latch_q;
    halt_run_d = halt_run_q;
    busy_d = busy_q;
    stage_d = stage_q;
    flag_set = 2'h0;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    rbyte = 8'h00;
    // Sync progress: each busy register counts ticks until it applies.
    for (int i = 0; i < 4; i++) begin
      if (busy_q[i] && rtc_tick) stage_d[i] = stage_q[i] + 2'h1;
      if (apply_w[i]) begin
        busy_d[i] = 1'b0; // [R6]
        stage_d[i] = 2'h0;
      end
    end
    if (apply_w[BUSY_CTRL]) ctrl_act_d = ctrl_q; // [R3]
    if (apply_w[BUSY_LIM]) lim_act_d = lim_q; // [R16]
    if (apply_w[BUSY_CMP]) cmp_act_d = cmp_q;
    // Counting; a count load arriving on the same tick takes priority.
    if (apply_w[BUSY_CNT]) begin
      cnt_d = cnt_new_q; // [R16]
    end else if (cnt_tick) begin
      if (cnt_q == lim_act_q) begin
        cnt_d = 16'h0000; // [R10]
        flag_set[IRQ_WRAP_BIT] = 1'b1; // [R10]
      end else begin
        cnt_d = cnt_q + 16'h0001; // [R23]
      end
    end
    if ((apply_w[BUSY_CNT] || cnt_tick) && cnt_d == cmp_act_q) begin
      flag_set[IRQ_MATCH_BIT] = 1'b1; // [R9]
    end
    // Bus writes; a rewrite while busy restarts that register's sync.
    if (wr_b0) begin
      unique case (widx)
        IDX_CTRL: begin
          ctrl_d = wbyte;
          busy_d[BUSY_CTRL] = 1'b1; // [R6]
          stage_d[BUSY_CTRL] = 2'h0;
        end
        IDX_IRQ_EN: en_d = wbyte[1:0]; // [R7] [R8]
        IDX_LATCH: latch_d = wbyte; // [R12]
        IDX_HALT: halt_run_d = wbyte[HALT_RUN_BIT];
        IDX_SRC: src_d = wbyte[1:0];
        IDX_CNT_HI, IDX_LIM_HI, IDX_CMP_HI: latch_d = wbyte; // [R22]
        IDX_CNT_LO: begin
          cnt_new_d = {latch_q, wbyte}; // [R22]
          busy_d[BUSY_CNT] = 1'b1;
          stage_d[BUSY_CNT] = 2'h0;
        end
        IDX_LIM_LO: begin
          lim_d = {latch_q, wbyte}; // [R22]
          busy_d[BUSY_LIM] = 1'b1;
          stage_d[BUSY_LIM] = 2'h0;
        end
        IDX_CMP_LO: begin
          cmp_d = {latch_q, wbyte};
          busy_d[BUSY_CMP] = 1'b1;
          stage_d[BUSY_CMP] = 2'h0;
        end
        default: ;
      endcase
    end
    if (wr) begin
      bvalid_d = 1'b1;
      bresp_d = wmapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Bus reads; a low-byte read parks the high byte in the latch.
    if (rd) begin
      unique case (ridx)
        IDX_CTRL: rbyte = ctrl_q;
        IDX_BUSY: rbyte = {4'h0, busy_q}; // [R6]
        IDX_IRQ_EN: rbyte = {6'h00, en_q};
        IDX_IRQ_FLAGS: rbyte = {6'h00, flags_q};
        IDX_LATCH: rbyte = latch_q; // [R12]
        IDX_HALT: rbyte = {7'h00, halt_run_q};
        IDX_SRC: rbyte = {6'h00, src_q};
        IDX_CNT_LO: begin
          rbyte = cnt_q[7:0];
          latch_d = cnt_q[15:8]; // [R22]
        end
        IDX_LIM_LO: begin
          rbyte = lim_q[7:0];
          latch_d = lim_q[15:8]; // [R22]
        end
        IDX_CMP_LO: begin
          rbyte = cmp_q[7:0];
          latch_d = cmp_q[15:8];
        end
        IDX_CNT_HI, IDX_LIM_HI, IDX_CMP_HI: rbyte = latch_q; // [R12]
        default: rbyte = 8'h00;
      endcase
      rvalid_d = 1'b1;
      rdata_d = {24'h000000, rbyte};
      rresp_d = rmapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // A set in the same cycle as a write-one clear wins.
    flags_d = flags_q;
    if (wr_b0 && widx == IDX_IRQ_FLAGS) begin
      flags_d = flags_q & ~wbyte[1:0]; // [R11]
    end
    flags_d = flags_d | flag_set;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= BYTE_RST;
      ctrl_act_q <= BYTE_RST;
      cnt_q <= CNT_RST; // [R15]
      cnt_new_q <= CNT_RST;
      lim_q <= LIM_RST; // [R18]
      lim_act_q <= LIM_RST;
      cmp_q <= CMP_RST;
      cmp_act_q <= CMP_RST;
      en_q <= 2'h0;
      flags_q <= 2'h0;
      src_q <= SRC_FAST;
      latch_q <= BYTE_RST;
      halt_run_q <= 1'b0;
      busy_q <= 4'h0;
      for (int i = 0; i < 4; i++) stage_q[i] <= 2'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else begin
      ctrl_q <= ctrl_d;
      ctrl_act_q <= ctrl_act_d;
      cnt_q <= cnt_d;
      cnt_new_q <= cnt_new_d;
      lim_q <= lim_d;
      lim_act_q <= lim_act_d;
      cmp_q <= cmp_d;
      cmp_act_q <= cmp_act_d;
      en_q <= en_d;
      flags_q <= flags_d;
      src_q <= src_d;
      latch_q <= latch_d;
      halt_run_q <= halt_run_d;
      busy_q <= busy_d;
      stage_q <= stage_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // The request is a level that falls as soon as the flag is cleared.
  assign irq_o = |(flags_q & en_q); // [R20] [R7] [R8]

  // Checks on the timekeeping path and the register side effects.
  sequence wr_cnt_lo_s;
    wr_b0 && widx == IDX_CNT_LO;
  endsequence
  sequence rd_cnt_lo_s;
    rd && ridx == IDX_CNT_LO;
  endsequence
  ctrl_hold_a: assert property ( // [R3]
    busy_q[BUSY_CTRL] && !apply_w[BUSY_CTRL] |=> $stable(ctrl_act_q))
    else $error("control copy changed before its sync finished");
  ctrl_apply_a: assert property ( // [R3]
    apply_w[BUSY_CTRL] && !wr_b0 |=> ctrl_act_q == ctrl_q && !busy_q[0])
    else $error("control sync did not land");
  busy_read_a: assert property ( // [R6]
    rd && ridx == IDX_BUSY |=> rdata_q[3:0] == $past(busy_q))
    else $error("busy flags read back wrong");
  div_one_a: assert property ( // [R2]
    rtc_tick && run && ctrl_act_q[6:3] == 4'h0 |-> cnt_tick)
    else $error("divide-by-one skipped a tick");
  off_hold_a: assert property ( // [R5]
    !ctrl_act_q[CTRL_ON_BIT] && !apply_w[BUSY_CNT] |=> $stable(cnt_q))
    else $error("counter moved while disabled");
  wrap_zero_a: assert property ( // [R10]
    cnt_tick && cnt_q == lim_act_q && !apply_w[BUSY_CNT]
    |=> cnt_q == 16'h0000 && flags_q[IRQ_WRAP_BIT])
    else $error("wrap did not clear count and set flag");
  step_one_a: assert property ( // [R23]
    cnt_tick && cnt_q != lim_act_q && !apply_w[BUSY_CNT]
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("count did not step by one");
  match_set_a: assert property ( // [R9]
    cnt_tick && !apply_w[BUSY_CNT] && cnt_q != lim_act_q
    && cnt_q + 16'h0001 == cmp_act_q |=> flags_q[IRQ_MATCH_BIT])
    else $error("match flag missed");
  flag_clear_a: assert property ( // [R11]
    wr_b0 && widx == IDX_IRQ_FLAGS && wbyte[0] && !flag_set[0]
    |=> !flags_q[IRQ_WRAP_BIT])
    else $error("write one did not clear wrap flag");
  halt_stop_a: assert property ( // [R13]
    debug_halt_i && !halt_run_q |-> !cnt_tick)
    else $error("counter ticked during debug halt");
  standby_stop_a: assert property ( // [R1]
    standby_i && !ctrl_act_q[CTRL_STANDBY_BIT] |-> !cnt_tick)
    else $error("counter ticked in standby");
  irq_gate_a: assert property ( // [R20]
    flags_q[IRQ_MATCH_BIT] && en_q[IRQ_MATCH_BIT] |-> irq_o)
    else $error("interrupt dropped while flag and enable set");
  cnt_commit_a: assert property ( // [R22]
    wr_cnt_lo_s |=> busy_q[BUSY_CNT]
    && cnt_new_q == {$past(latch_q), $past(wbyte)})
    else $error("low-byte write did not commit both bytes");
  latch_grab_a: assert property ( // [R22]
    rd_cnt_lo_s |=> latch_q == $past(cnt_q[15:8]))
    else $error("low-byte read did not latch high byte");

endmodule // rtc_counter_core

// ===== verilog/rtc_counter_pkg.sv
// Constants shared by the real-time counter core and its bench.
package rtc_counter_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam int unsigned ADDR_W = 6;
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_BUSY = 4'h1;
  localparam logic [3:0] IDX_IRQ_EN = 4'h2;
  localparam logic [3:0] IDX_IRQ_FLAGS = 4'h3;
  localparam logic [3:0] IDX_LATCH = 4'h4;
  localparam logic [3:0] IDX_HALT = 4'h5;
  localparam logic [3:0] IDX_SRC = 4'h7;
  localparam logic [3:0] IDX_CNT_LO = 4'h8;
  localparam logic [3:0] IDX_CNT_HI = 4'h9;
  localparam logic [3:0] IDX_LIM_LO = 4'ha;
  localparam logic [3:0] IDX_LIM_HI = 4'hb;
  localparam logic [3:0] IDX_CMP_LO = 4'hc;
  localparam logic [3:0] IDX_CMP_HI = 4'hd;

  // Field positions in main_control and the other byte registers.
  localparam int unsigned CTRL_ON_BIT = 0;
  localparam int unsigned CTRL_DIV_LSB = 3;
  localparam int unsigned CTRL_DIV_MSB = 6;
  localparam int unsigned CTRL_STANDBY_BIT = 7;
  localparam int unsigned BUSY_CTRL = 0;
  localparam int unsigned BUSY_CNT = 1;
  localparam int unsigned BUSY_LIM = 2;
  localparam int unsigned BUSY_CMP = 3;
  localparam int unsigned IRQ_WRAP_BIT = 0;
  localparam int unsigned IRQ_MATCH_BIT = 1;
  localparam int unsigned HALT_RUN_BIT = 0;

  // Source choice codes; code 2'h2 is reserved and gives no ticks.
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // Values after reset.
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] LIM_RST = 16'hffff;
  localparam logic [15:0] CMP_RST = 16'h0000;

  // Sync latency in timekeeping cycles and the fast-to-slow source ratio.
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  localparam int unsigned FAST_HZ = 32768;
  localparam int unsigned SLOW_HZ = 1024;
  localparam logic [4:0] SLOW_LAST = 5'(FAST_HZ / SLOW_HZ - 1);

  // AXI4-Lite responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== tb/tb.sv
// Self-checking bench for the real-time counter core over AXI4-Lite.
`timescale 1ns/1ps

module tb;
  import rtc_counter_pkg::*;

  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [ADDR_W-1:0] s_axi_awaddr = 6'h00;
  logic [ADDR_W-1:0] s_axi_araddr = 6'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic standby_i = 1'h0, debug_halt_i = 1'h0;
  logic low_power_osc_i, ext_clk_i;
  logic [4:0] phase_q = 5'h00;
  logic [7:0] v;
  int fails = 0;
  int checks = 0;
  logic [3:0] rst_idx [12] = '{IDX_CTRL, IDX_BUSY, IDX_IRQ_EN,
    IDX_IRQ_FLAGS, IDX_LATCH, IDX_HALT, IDX_SRC, IDX_CNT_LO, IDX_CNT_HI,
    IDX_LIM_LO, IDX_LIM_HI, IDX_CMP_LO};
  logic [7:0] rst_val [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
  logic [3:0] div_code [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
  logic [7:0] div_exp [4] = '{8'h14, 8'h0a, 8'h05, 8'h00};
  logic [1:0] src_code [3] = '{2'h1, 2'h2, 2'h3};
  logic [7:0] src_exp [3] = '{8'h02, 8'h00, 8'h20};

  always #20 clk_i = ~clk_i;

  // Oscillator pin rises every 16 clocks, the external pin every 32.
  always @(posedge clk_i) phase_q <= phase_q + 5'h01;
  assign low_power_osc_i = phase_q[3];
  assign ext_clk_i = phase_q[4];

  rtc_counter_core rtc_counter_core_i (.clk_i, .rst_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .low_power_osc_i, .ext_clk_i, .standby_i, .debug_halt_i, .irq_o);

  task report_and_stop;
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data go out together; each drops once its own ready is seen.
  task wr(input logic [3:0] idx, input logic [7:0] d);
    logic aw_done, w_done;
    @(posedge clk_i);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    aw_done = 1'h0;
    w_done = 1'h0;
    while (!(aw_done && w_done)) begin
      @(posedge clk_i);
      if (!aw_done && s_axi_awready === 1'h1) begin
        aw_done = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_done && s_axi_wready === 1'h1) begin
        w_done = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clk_i); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk({6'h00, s_axi_bresp}, {6'h00, idx == 4'he ? RESP_SLVERR : RESP_OKAY});
  endtask

  // Read data and response are taken at the edge where rvalid is seen.
  task rd(input logic [3:0] idx, output logic [7:0] d);
    @(posedge clk_i);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk_i); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_i); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata[7:0];
    chk({6'h00, s_axi_rresp}, {6'h00, idx == 4'h6 ? RESP_SLVERR : RESP_OKAY});
  endtask

  task rdchk(input logic [3:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    rd(idx, d);
    chk(d, exp);
  endtask

  // Software must see every busy bit clear before the next synced write.
  task settle;
    logic [7:0] d;
    d = 8'hff;
    while (d !== 8'h00) rd(IDX_BUSY, d);
  endtask

  // Counts steps of the low count byte over a span; one step of slack
  // covers the unknown phase of the source against the span.
  task meas(input int n, input logic [7:0] exp);
    logic [7:0] a, b, lo;
    lo = (exp == 8'h00) ? 8'h00 : exp - 8'h01;
    rd(IDX_CNT_LO, a);
    repeat (n) @(posedge clk_i);
    rd(IDX_CNT_LO, b);
    b = b - a;
    checks++;
    if ((b >= lo && b <= exp + (lo != 8'h00)) !== 1'h1) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, b, exp);
    end
  endtask

  // Main sequence of register-level scenarios.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (rst_idx[k]) rdchk(rst_idx[k], rst_val[k]);
    rd(4'h6, v);
    chk(v, 8'h00);
    wr(4'he, 8'h55);
    wr(IDX_BUSY, 8'hff);
    wr(IDX_LIM_HI, 8'h00);
    wr(IDX_LIM_LO, 8'h03);
    rdchk(IDX_BUSY, 8'h04);
    // Compare equals the limit: match on the step to 3, wrap on the next.
    wr(IDX_CMP_HI, 8'h00);
    wr(IDX_CMP_LO, 8'h03);
    rdchk(IDX_BUSY, 8'h0c);
    settle;
    rdchk(IDX_CMP_LO, 8'h03);
    wr(IDX_IRQ_EN, 8'h03);
    wr(IDX_CTRL, 8'h01);
    rdchk(IDX_BUSY, 8'h01);
    settle;
    for (int i = 0; i < 200 && irq_o !== 1'h1; i++) @(posedge clk_i);
    chk({7'h00, irq_o}, 8'h01);
    wr(IDX_CTRL, 8'h00);
    settle;
    rdchk(IDX_IRQ_FLAGS, 8'h03);
    meas(200, 8'h00);
    wr(IDX_IRQ_FLAGS, 8'h00);
    rdchk(IDX_IRQ_FLAGS, 8'h03);
    wr(IDX_IRQ_EN, 8'h01);
    chk({7'h00, irq_o}, 8'h01);
    wr(IDX_IRQ_FLAGS, 8'h01);
    chk({7'h00, irq_o}, 8'h00);
    wr(IDX_IRQ_EN, 8'h02);
    chk({7'h00, irq_o}, 8'h01);
    wr(IDX_IRQ_FLAGS, 8'h02);
    chk({7'h00, irq_o}, 8'h00);
    rdchk(IDX_IRQ_FLAGS, 8'h00);
    wr(IDX_CNT_HI, 8'h12);
    wr(IDX_CNT_LO, 8'h34);
    rdchk(IDX_BUSY, 8'h02);
    settle;
    rdchk(IDX_CNT_LO, 8'h34);
    rdchk(IDX_LATCH, 8'h12);
    rdchk(IDX_CNT_HI, 8'h12);
    wr(IDX_LATCH, 8'h5a);
    rdchk(IDX_CNT_HI, 8'h5a);
    wr(IDX_LIM_HI, 8'hff);
    wr(IDX_LIM_LO, 8'hff);
    settle;
    // Divider codes 0, 1, 2 and 15 scale the step rate of the fast source.
    foreach (div_code[k]) begin
      wr(IDX_CTRL, {1'h0, div_code[k], 3'h1});
      settle;
      meas(320, div_exp[k]);
    end
    wr(IDX_CTRL, 8'h01);
    settle;
    standby_i <= 1'h1;
    meas(320, 8'h00);
    standby_i <= 1'h0;
    wr(IDX_CTRL, 8'h81);
    settle;
    standby_i <= 1'h1;
    meas(320, 8'h14);
    standby_i <= 1'h0;
    debug_halt_i <= 1'h1;
    meas(320, 8'h00);
    wr(IDX_HALT, 8'h01);
    meas(320, 8'h14);
    debug_halt_i <= 1'h0;
    // Slow, reserved and external sources, each over its own 1024-clock span.
    foreach (src_code[k]) begin
      wr(IDX_SRC, {6'h00, src_code[k]});
      meas(1024, src_exp[k]);
    end
    report_and_stop;
  end

  // The whole sequence needs well under 20000 clocks.
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    report_and_stop;
  end
endmodule // tb
